// ### core/sysint_pkg.sv
// shared constants and types for the break, low-power and reset-cause block
package sysint_pkg;
  // ----------------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADR_BRK_STAT  = 16'hFE00; // break_status_reg
  localparam logic [15:0] ADR_RST_CAUSE = 16'hFE01; // reset_cause_reg
  localparam logic [15:0] ADR_BRK_CTRL  = 16'hFE03; // break_flag_control_reg
  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BIT_STOP_WAIT = 1; // break_stop_wait_flag
  localparam int BIT_CLR_EN    = 7; // break_flag_clear_enable
  localparam int BIT_POR       = 7; // power-on cause
  localparam int BIT_PIN       = 6; // external pin cause
  localparam int BIT_WDOG      = 5; // watchdog_reset_cause
  localparam int BIT_ILLEGAL_OPCODE_CAUSE      = 4; // illegal_opcode_cause
  localparam int BIT_ILLEGAL_ADDRESS_CAUSE      = 3; // illegal_address_cause
  localparam int BIT_USB       = 2; // usb reset cause
  localparam int BIT_LVI       = 1; // low_voltage_cause
  // ----------------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0] CAUSE_AT_POR = 8'h80;  // only power-on bit set
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam int RECOV_LONG_CYC  = 4096; // oscillator_clock cycles
  localparam int RECOV_SHORT_CYC = 32;   // with short_recovery_select
  localparam int CNT_W           = 13;   // wide enough for long recovery
  // ----------------------------------------------------------------------
  // low-power sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN,
    ST_WAIT,
    ST_STOP,
    ST_RECOVER
  } mode_e;
endpackage : sysint_pkg

// ### core/sysint_break_lowpower.sv
// break state, flag protection, wait/stop sequencing and reset cause
`timescale 1ns/10ps
module sysint_break_lowpower
#(
  parameter int RECOV_LONG  = sysint_pkg::RECOV_LONG_CYC,
  parameter int RECOV_SHORT = sysint_pkg::RECOV_SHORT_CYC
)
(
  input  wire logic        CLK_SYS,          // oscillator_clock, 40 MHz
  input  wire logic        ARST_N,           // power-on reset
  input  wire logic [15:0] ADDR,             // register address
  input  wire logic [7:0]  WDATA,            // register write data
  input  wire logic        WR,               // write strobe
  input  wire logic        RD,               // read strobe
  output logic      [7:0]  RDATA,            // read data, cycle after RD
  input  wire logic        BREAK_REQ,        // break module request
  input  wire logic        BREAK_END,        // cpu leaves break state
  input  wire logic        WAIT_EXEC,        // wait instruction pulse
  input  wire logic        STOP_EXEC,        // stop instruction pulse
  input  wire logic        IRQ_PEND,         // enabled module interrupt
  input  wire logic        RST_PIN,          // external pin reset event
  input  wire logic        RST_WDOG,         // watchdog reset event
  input  wire logic        RST_ILLEGAL_OPCODE_CAUSE,         // illegal opcode reset event
  input  wire logic        RST_ILLEGAL_ADDRESS_CAUSE,         // illegal address reset event
  input  wire logic        RST_USB,          // usb reset event
  input  wire logic        RST_LVI,          // low voltage reset event
  input  wire logic        SHORT_RECOVERY,   // short_recovery_select
  input  wire logic        WDOG_DISABLE_OPT, // watchdog_disable_option
  output logic             CPU_CLK_EN,       // cpu clock gate
  output logic             PERIPH_CLK_EN,    // peripheral clock gate
  output logic             CLK_GEN_EN,       // clock_gen_output enable
  output logic             FORCE_SWI_VEC,    // fetch swi vector, pulse
  output logic             BREAK_ACTIVE,     // cpu in break state
  output logic             FLAG_CLEAR_OK,    // peripherals may clear flags
  output logic             CLEAR_IMASK,      // clear cpu I bit, pulse
  output logic             STACK_START,      // begin interrupt stacking
  output logic             WDOG_RUN          // watchdog enabled
);
  import sysint_pkg::*;

  // ----------------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------------
  typedef struct packed {
    mode_e              mode;      // low-power sequencer
    logic               brk;       // break state
    logic               clr_en;    // break_flag_clear_enable
    logic               stop_wait; // break_stop_wait_flag
    logic [7:0]         cause;     // reset_cause_reg image
    logic [CNT_W-1:0]   cnt;       // stop recovery counter
    logic               brk_wake;  // break waiting for recovery end
    logic [7:0]         rdata;
    logic               cpu_clk;
    logic               per_clk;
    logic               cgm;
    logic               software_interrupt;
    logic               imask;
    logic               stack;
    logic               clr_ok;
    logic               wdog;
  } state_s;

  state_s s;       // registered state
  state_s next_s;  // next state

  logic             rst_any;   // any internal or pin reset event
  logic             sw_set;    // stop/wait flag raised this cycle
  logic [7:0]       cause_set; // cause bits raised this cycle
  logic [CNT_W-1:0] recov_end; // last count of recovery
  logic             recov_done;

  // ----------------------------------------------------------------------
  // helper terms
  // ----------------------------------------------------------------------
  // one cause bit per source; the option inputs are read directly since
  // they are static configuration
  always_comb
  begin
    cause_set            = BYTE_ZERO;
    cause_set[BIT_PIN]   = RST_PIN;
    cause_set[BIT_WDOG]  = RST_WDOG;
    cause_set[BIT_ILLEGAL_OPCODE_CAUSE]  = RST_ILLEGAL_OPCODE_CAUSE;
    cause_set[BIT_ILLEGAL_ADDRESS_CAUSE]  = RST_ILLEGAL_ADDRESS_CAUSE;
    cause_set[BIT_USB]   = RST_USB;
    cause_set[BIT_LVI]   = RST_LVI;
    rst_any              = |cause_set;
    // recovery length follows the short option
    recov_end  = SHORT_RECOVERY ? CNT_W'(RECOV_SHORT - 1)
                                : CNT_W'(RECOV_LONG - 1);
    recov_done = (s.cnt == recov_end);
  end

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s       = s;
    next_s.software_interrupt   = 1'b0;
    next_s.imask = 1'b0;
    next_s.stack = 1'b0;
    next_s.rdata = BYTE_ZERO;
    sw_set       = 1'b0;

    // sequencer
    unique case (s.mode)
      ST_RUN:
      begin
        if (!rst_any && BREAK_REQ && !s.brk)
        begin
          next_s.brk = 1'b1;
          next_s.software_interrupt = 1'b1;
        end
        else if (!rst_any && WAIT_EXEC)
        begin
          next_s.mode  = ST_WAIT;
          next_s.imask = 1'b1;
        end
        else if (!rst_any && STOP_EXEC)
        begin
          next_s.mode  = ST_STOP;
          next_s.imask = 1'b1;
          // the count left by an earlier recovery must not leak into stop
          next_s.cnt   = '0;
        end
      end
      ST_WAIT:
      begin
        // reset beats break, break beats interrupt
        if (rst_any)
          next_s.mode = ST_RUN;
        else if (BREAK_REQ)
        begin
          next_s.mode      = ST_RUN;
          next_s.brk       = 1'b1;
          next_s.software_interrupt       = 1'b1;
          next_s.stop_wait = 1'b1;
          sw_set           = 1'b1;
        end
        else if (IRQ_PEND)
        begin
          next_s.mode  = ST_RUN;
          next_s.stack = 1'b1;
        end
      end
      ST_STOP:
      begin
        next_s.cnt = '0;
        if (rst_any)
          next_s.mode = ST_RUN;
        else if (BREAK_REQ || IRQ_PEND)
        begin
          next_s.mode      = ST_RECOVER;
          next_s.brk_wake  = BREAK_REQ;
          next_s.stop_wait = s.stop_wait | BREAK_REQ;
          sw_set           = BREAK_REQ;
        end
      end
      ST_RECOVER:
      begin
        if (rst_any)
        begin
          next_s.mode     = ST_RUN;
          next_s.brk_wake = 1'b0;
        end
        else if (recov_done)
        begin
          // stacking waits for the full recovery time
          next_s.mode     = ST_RUN;
          next_s.brk_wake = 1'b0;
          next_s.brk      = s.brk_wake;
          next_s.software_interrupt      = s.brk_wake;
          next_s.stack    = !s.brk_wake;
        end
        else
          next_s.cnt = s.cnt + CNT_W'(1);
      end
    endcase

    // leaving break returns normal clearing; cleared flags are not restored
    if (BREAK_END && !next_s.software_interrupt)
      next_s.brk = 1'b0;
    if (rst_any)
      next_s.brk = 1'b0;

    // register writes
    if (WR && ADDR == ADR_BRK_CTRL)
      next_s.clr_en = WDATA[BIT_CLR_EN];
    // writing 0 clears; a break in the same cycle still sets
    if (WR && ADDR == ADR_BRK_STAT && !WDATA[BIT_STOP_WAIT]
        && !sw_set)
      next_s.stop_wait = 1'b0;
    if (rst_any)
      next_s.stop_wait = 1'b0;

    // reset cause: read clears, new events win over the clear
    if (RD && ADDR == ADR_RST_CAUSE)
      next_s.cause = BYTE_ZERO;
    next_s.cause = next_s.cause | cause_set;

    // register reads, one cycle later; unmapped reads as zero
    if (RD)
    begin
      unique case (ADDR)
        ADR_BRK_STAT:  next_s.rdata[BIT_STOP_WAIT] = s.stop_wait;
        ADR_RST_CAUSE: next_s.rdata = s.cause;
        ADR_BRK_CTRL:  next_s.rdata[BIT_CLR_EN] = s.clr_en;
        default:       next_s.rdata = BYTE_ZERO;
      endcase
    end

    // clock gates and permissions follow the next state
    next_s.cpu_clk = (next_s.mode == ST_RUN);
    next_s.per_clk = (next_s.mode != ST_STOP)
                     && (next_s.mode != ST_RECOVER);
    next_s.cgm     = (next_s.mode != ST_STOP);
    // a second step issued in break is refused unless break_flag_clear_enable is set
    next_s.clr_ok  = !next_s.brk || next_s.clr_en;
    next_s.wdog    = !WDOG_DISABLE_OPT;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // power-on reset leaves only the power-on cause bit set
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s          <= '0;
      s.mode     <= ST_RUN;
      s.cause    <= CAUSE_AT_POR;
      s.cpu_clk  <= 1'b1;
      s.per_clk  <= 1'b1;
      s.cgm      <= 1'b1;
      s.clr_ok   <= 1'b1;
      s.wdog     <= 1'b1;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------------
  // outputs straight from flip-flops
  // ----------------------------------------------------------------------
  assign RDATA         = s.rdata;
  assign CPU_CLK_EN    = s.cpu_clk;
  assign PERIPH_CLK_EN = s.per_clk;
  assign CLK_GEN_EN    = s.cgm;
  assign FORCE_SWI_VEC = s.software_interrupt;
  assign BREAK_ACTIVE  = s.brk;
  assign FLAG_CLEAR_OK = s.clr_ok;
  assign CLEAR_IMASK   = s.imask;
  assign STACK_START   = s.stack;
  assign WDOG_RUN      = s.wdog;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  property p_brk_vec;
    s.mode == ST_RUN && !s.brk && BREAK_REQ && !rst_any
    |=> FORCE_SWI_VEC && BREAK_ACTIVE;
  endproperty
  a_brk_vec: assert property (p_brk_vec)
    else $error("break did not force the swi vector");

  property p_clr_block;
    BREAK_ACTIVE |-> FLAG_CLEAR_OK == s.clr_en;
  endproperty
  a_clr_block: assert property (p_clr_block)
    else $error("flag clearing permission wrong in break");

  property p_wait_entry;
    s.mode == ST_RUN && !s.brk && !BREAK_REQ && WAIT_EXEC && !rst_any
    |=> CLEAR_IMASK && !CPU_CLK_EN && PERIPH_CLK_EN ##1 !CLEAR_IMASK;
  endproperty
  a_wait_entry: assert property (p_wait_entry)
    else $error("wait entry gating or mask clear wrong");

  property p_wait_wake;
    s.mode == ST_WAIT && IRQ_PEND && !BREAK_REQ && !rst_any
    |=> STACK_START && CPU_CLK_EN;
  endproperty
  a_wait_wake: assert property (p_wait_wake)
    else $error("wait wake stacking not one cycle later");

  property p_brk_flag;
    s.mode == ST_WAIT && BREAK_REQ && !rst_any |=> s.stop_wait;
  endproperty
  a_brk_flag: assert property (p_brk_flag)
    else $error("break out of wait did not set the flag");

  property p_stop_hold;
    s.mode == ST_STOP |-> !CLK_GEN_EN && !PERIPH_CLK_EN && s.cnt == '0;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop mode clocks or counter not held");

  property p_stop_entry;
    s.mode == ST_RUN && !BREAK_REQ && !WAIT_EXEC && STOP_EXEC && !rst_any
    |=> CLEAR_IMASK && !CLK_GEN_EN && !CPU_CLK_EN && s.cnt == '0;
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("stop entry gating, mask clear or counter wrong");

  property p_wait_rst;
    s.mode == ST_WAIT && rst_any
    |=> CPU_CLK_EN && !BREAK_ACTIVE && !STACK_START && !FORCE_SWI_VEC;
  endproperty
  a_wait_rst: assert property (p_wait_rst)
    else $error("reset did not end wait mode cleanly");

  property p_recov_end;
    s.mode == ST_RECOVER && !rst_any && s.cnt == recov_end
    |=> (STACK_START || FORCE_SWI_VEC) && s.mode == ST_RUN;
  endproperty
  a_recov_end: assert property (p_recov_end)
    else $error("stop recovery did not end on its count");

  property p_recov_count;
    s.mode == ST_RECOVER && !rst_any && s.cnt != recov_end
    |=> !STACK_START && s.cnt == $past(s.cnt) + CNT_W'(1);
  endproperty
  a_recov_count: assert property (p_recov_count)
    else $error("recovery counter did not advance");

  property p_flag_wr0;
    WR && ADDR == ADR_BRK_STAT && !WDATA[BIT_STOP_WAIT]
    && s.mode == ST_RUN |=> !s.stop_wait;
  endproperty
  a_flag_wr0: assert property (p_flag_wr0)
    else $error("writing zero did not clear the stop/wait flag");

  property p_cause_rd;
    RD && ADDR == ADR_RST_CAUSE && !rst_any
    |=> RDATA == $past(s.cause) && s.cause == BYTE_ZERO;
  endproperty
  a_cause_rd: assert property (p_cause_rd)
    else $error("reset cause read did not clear");

  property p_cause_set;
    RST_WDOG |=> s.cause[BIT_WDOG] && !s.brk;
  endproperty
  a_cause_set: assert property (p_cause_set)
    else $error("watchdog cause bit not set");

  c_wait_wake: cover property (s.mode == ST_WAIT ##1 STACK_START);
  c_stop_done: cover property (s.mode == ST_RECOVER ##1 STACK_START);
  c_brk_stop:  cover property (s.mode == ST_STOP && BREAK_REQ);
  c_cause_rd:  cover property (RD && ADDR == ADR_RST_CAUSE);
  c_wait_brk:  cover property (s.mode == ST_WAIT && BREAK_REQ);
endmodule : sysint_break_lowpower

// ### tb/periph_flag_model.sv
// peripheral status flag with a two-step clear, under break protection
`timescale 1ns/10ps
module periph_flag_model
(
  input  wire logic clk,           // oscillator clock
  input  wire logic arst_n,        // power-on reset, active low
  input  wire logic flag_clear_ok, // clear permission from the block
  input  wire logic set_evt,       // hardware event sets the flag
  input  wire logic step_one,      // first access of the clear sequence
  input  wire logic step_two,      // second access of the clear sequence
  output logic      flag           // status flag seen by software
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed
  {
    logic flag;  // status flag
    logic armed; // first step seen, second step pending
  } flag_s;
  flag_s cur;      // registered state
  flag_s next_cur; // next state
  // next state: a set event wins over a clear in the same cycle
  always_comb
  begin
    next_cur = cur;
    if (step_one)
    begin
      next_cur.armed = 1'b1;
    end
    // armed survives a blocked second step, so the clear ends later
    if (step_two && cur.armed && flag_clear_ok)
    begin
      next_cur.flag  = 1'b0; // nothing restores a flag once cleared
      next_cur.armed = 1'b0;
    end
    if (set_evt)
    begin
      next_cur.flag = 1'b1;
    end
  end
  // register the state
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end
  assign flag = cur.flag;
endmodule : periph_flag_model

// ### tb/testbench.sv
// self-checking bench for the break, low-power and reset-cause block
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp); \
    end \
  end
module testbench;
  import sysint_pkg::*;
  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  localparam int N_LONG  = 40; // shortened long recovery
  localparam int N_SHORT = 8;  // shortened short recovery
  localparam logic [12:0] EV_BRK = 13'h0001; // break request
  localparam logic [12:0] EV_END = 13'h0002; // cpu leaves break
  localparam logic [12:0] EV_WAI = 13'h0004; // wait instruction
  localparam logic [12:0] EV_STP = 13'h0008; // stop instruction
  localparam logic [12:0] EV_SET = 13'h0010; // peripheral flag set
  localparam logic [12:0] EV_ONE = 13'h0020; // first clear access
  localparam logic [12:0] EV_TWO = 13'h0040; // second clear access
  typedef struct packed
  {
    logic [5:0] src;   // reset sources, pin down to low voltage
    logic [7:0] cause; // expected cause byte
  } row_s;
  row_s        rows [7];        // reset-cause cases
  logic        clk_sys;         // 40 MHz clock
  logic        arst_n;          // power-on reset
  logic [15:0] addr;            // register address
  logic [7:0]  wdata;           // register write data
  logic        wr;              // write strobe
  logic        rd;              // read strobe
  logic [7:0]  rdata;           // read data
  logic [12:0] ev;              // one-cycle event pulses
  logic        irq_pend;        // module interrupt level
  logic        short_rec;       // short recovery option
  logic        wdog_dis;        // watchdog disable option
  logic        cpu_clk_en;      // cpu clock gate
  logic        periph_clk_en;   // peripheral clock gate
  logic        clk_gen_en;      // clock generator enable
  logic        force_swi;       // vector redirect pulse
  logic        break_active;    // break state
  logic        flag_clear_ok;   // clear permission
  logic        clear_imask;     // mask clear pulse
  logic        stack_start;     // stacking pulse
  logic        wdog_run;        // watchdog enabled
  logic        pflag;           // peripheral flag
  int          error_cnt;       // mismatches
  int          samples_checked; // comparisons made
  int          k;               // recovery cycle count
  sysint_break_lowpower #(.RECOV_LONG(N_LONG), .RECOV_SHORT(N_SHORT)) DUT
  (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .BREAK_REQ(ev[0]),
    .BREAK_END(ev[1]), .WAIT_EXEC(ev[2]), .STOP_EXEC(ev[3]),
    .IRQ_PEND(irq_pend), .RST_PIN(ev[12]), .RST_WDOG(ev[11]),
    .RST_ILLEGAL_OPCODE_CAUSE(ev[10]), .RST_ILLEGAL_ADDRESS_CAUSE(ev[9]), .RST_USB(ev[8]),
    .RST_LVI(ev[7]), .SHORT_RECOVERY(short_rec),
    .WDOG_DISABLE_OPT(wdog_dis), .CPU_CLK_EN(cpu_clk_en),
    .PERIPH_CLK_EN(periph_clk_en), .CLK_GEN_EN(clk_gen_en),
    .FORCE_SWI_VEC(force_swi), .BREAK_ACTIVE(break_active),
    .FLAG_CLEAR_OK(flag_clear_ok), .CLEAR_IMASK(clear_imask),
    .STACK_START(stack_start), .WDOG_RUN(wdog_run)
  );
  periph_flag_model periph
  (
    .clk(clk_sys), .arst_n(arst_n), .flag_clear_ok(flag_clear_ok),
    .set_evt(ev[4]), .step_one(ev[5]), .step_two(ev[6]), .flag(pflag)
  );
  // ----------------------------------------------------------------------
  // clock and bus tasks
  // ----------------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // one-cycle pulse; outputs of the following cycle are settled on return
  task automatic fire(input logic [12:0] v);
    @(posedge clk_sys);
    ev <= v;
    @(posedge clk_sys);
    ev <= '0;
    #1;
  endtask : fire
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : reg_wr
  // read data is looked at only in the cycle after the strobe
  task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    `CHK(rdata, exp)
  endtask : reg_rd
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {arst_n, addr, wdata, wr, rd, ev, irq_pend, short_rec, wdog_dis} = '0;
    error_cnt = 0;
    samples_checked = 0;
    rows = '{'{6'h20, 8'h40}, '{6'h10, 8'h20}, '{6'h08, 8'h10},
             '{6'h04, 8'h08}, '{6'h02, 8'h04}, '{6'h01, 8'h02},
             '{6'h03, 8'h06}};
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1;
    `CHK({cpu_clk_en, periph_clk_en, clk_gen_en, wdog_run}, 4'hF)
    reg_rd(ADR_BRK_STAT, 8'h00);
    reg_rd(ADR_RST_CAUSE, 8'h80);
    reg_rd(ADR_BRK_CTRL, 8'h00);
    reg_rd(16'hFE02, 8'h00);
    // each source sets its own bit; a read empties the register
    for (int i = 0; i < 7; i++)
    begin
      fire({rows[i].src, 7'h00});
      reg_rd(ADR_RST_CAUSE, rows[i].cause);
      reg_rd(ADR_RST_CAUSE, 8'h00);
    end
    reg_wr(ADR_RST_CAUSE, 8'hFF);
    reg_rd(ADR_RST_CAUSE, 8'h00);
    done("reset_cause");
    // a half-done two-step clear must not finish inside break unless break_flag_clear_enable is set
    fire(EV_SET);
    fire(EV_ONE);
    fire(EV_BRK);
    `CHK({force_swi, break_active, flag_clear_ok}, 3'b110)
    fire(EV_TWO);
    `CHK(pflag, 1'b1)
    fire(EV_END);
    `CHK({break_active, flag_clear_ok}, 2'b01)
    fire(EV_TWO);
    `CHK(pflag, 1'b0)
    reg_wr(ADR_BRK_CTRL, 8'h80);
    reg_rd(ADR_BRK_CTRL, 8'h80);
    fire(EV_SET);
    fire(EV_BRK);
    `CHK({break_active, flag_clear_ok}, 2'b11)
    fire(EV_ONE);
    fire(EV_TWO);
    fire(EV_END);
    `CHK(pflag, 1'b0)
    reg_wr(ADR_BRK_CTRL, 8'h00);
    fire(EV_BRK);
    fire({6'h20, 7'h00});
    `CHK(break_active, 1'b0)
    reg_rd(ADR_RST_CAUSE, 8'h40);
    done("break_protection");
    // wait: cpu gated, peripherals and watchdog run, interrupt wakes
    fire(EV_WAI);
    `CHK({clear_imask, cpu_clk_en, periph_clk_en, wdog_run}, 4'hB)
    @(posedge clk_sys);
    irq_pend <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK({stack_start, cpu_clk_en}, 2'b11)
    irq_pend <= 1'b0;
    fire(EV_WAI);
    fire(EV_BRK);
    `CHK({force_swi, break_active, cpu_clk_en}, 3'b111)
    reg_rd(ADR_BRK_STAT, 8'h02);
    reg_wr(ADR_BRK_STAT, 8'hFF);
    reg_rd(ADR_BRK_STAT, 8'h02);
    reg_wr(ADR_BRK_STAT, 8'h00);
    reg_rd(ADR_BRK_STAT, 8'h00);
    fire(EV_END);
    // a reset event also ends wait mode, without stacking
    fire(EV_WAI);
    fire({6'h01, 7'h00});
    `CHK({cpu_clk_en, stack_start}, 2'b10)
    reg_rd(ADR_RST_CAUSE, 8'h02);
    wdog_dis <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(wdog_run, 1'b0)
    wdog_dis <= 1'b0;
    done("wait_mode");
    // stop: short recovery left by interrupt, long recovery by break
    for (int i = 0; i < 2; i++)
    begin
      short_rec <= (i == 0);
      fire(EV_STP);
      `CHK(clear_imask, 1'b1)
      `CHK({clk_gen_en, cpu_clk_en, periph_clk_en}, 3'h0)
      repeat (3) @(posedge clk_sys);
      if (i == 0)
        irq_pend <= 1'b1;
      else
        ev <= EV_BRK;
      @(posedge clk_sys);
      ev <= '0;
      #1;
      `CHK({clk_gen_en, cpu_clk_en, periph_clk_en}, 3'b100)
      k = 1;
      while (stack_start !== 1'b1 && force_swi !== 1'b1 && k < 100)
      begin
        @(posedge clk_sys);
        #1;
        k++;
      end
      if (k >= 100)
      begin
        $display("[FAIL] %0t ns: recovery wait timed out", $time);
        error_cnt++;
        summarize();
      end
      `CHK(k, 1 + ((i == 0) ? N_SHORT : N_LONG))
      `CHK({stack_start, force_swi, cpu_clk_en}, i ? 3'h3 : 3'h5)
      irq_pend <= 1'b0;
      reg_rd(ADR_BRK_STAT, (i == 0) ? 8'h00 : 8'h02);
      if (i == 1)
        fire(EV_END);
    end
    done("stop_mode");
    // power-on reset in mid-run clears the flag and control bit
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    reg_rd(ADR_BRK_STAT, 8'h00);
    reg_rd(ADR_RST_CAUSE, 8'h80);
    reg_rd(ADR_BRK_CTRL, 8'h00);
    done("second_reset");
    summarize();
  end
endmodule : testbench
